/* core/ewd_pkg.sv */
package ewd_pkg;

  // ==========================================================
  // Task-file offsets
  localparam int          TF_AW           = 4;
  localparam logic [3:0]  TF_FEAT_ERR     = 4'h1;
  localparam logic [3:0]  TF_SECCNT       = 4'h2;
  localparam logic [3:0]  TF_SECNUM       = 4'h3;
  localparam logic [3:0]  TF_CYL_LO       = 4'h4;
  localparam logic [3:0]  TF_CYL_HI       = 4'h5;
  localparam logic [3:0]  TF_DEVHEAD      = 4'h6;
  localparam logic [3:0]  TF_CMD_STAT     = 4'h7;
  localparam logic [3:0]  TF_DEVCTL       = 4'h8;

  // Index of each current/previous pair
  localparam int          PR_FEAT         = 0;
  localparam int          PR_SECCNT       = 1;
  localparam int          PR_SECNUM       = 2;
  localparam int          PR_CYL_LO       = 3;
  localparam int          PR_CYL_HI       = 4;
  localparam int          NUM_PAIRS       = 5;

  // ==========================================================
  // Command codes
  localparam logic [7:0]  OP_WRITE_EXT    = 8'h35;
  localparam logic [7:0]  OP_WRITE_QUEUED = 8'h61;

  // ==========================================================
  // Field positions
  localparam int          ST_BSY          = 7;
  localparam int          ST_RDY          = 6;
  localparam int          ST_FLT          = 5;
  localparam int          ST_SEEK         = 4;
  localparam int          ST_DRQ          = 3;
  localparam int          ST_CORR         = 2;
  localparam int          ST_ERR          = 0;
  localparam int          ER_CRC          = 7;
  localparam int          ER_NOTFND       = 4;
  localparam int          ER_ABORT        = 2;
  localparam int          DH_FORCED       = 7;
  localparam int          DC_HIBYTE       = 7;
  localparam int          TAG_LSB         = 3;
  localparam int          URG_LSB         = 6;
  localparam int          DL_COARSE       = 7;

  // ==========================================================
  // Urgency classes
  localparam logic [1:0]  URG_NORMAL      = 2'h0;
  localparam logic [1:0]  URG_ISOCH       = 2'h1;
  localparam logic [1:0]  URG_HIGH        = 2'h2;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [16:0] ZERO_COUNT_SECS = 17'h1_0000;

  // ==========================================================
  // Timing
  localparam int          CLK_MHZ         = 125;
  localparam int          FINE_UNIT_US    = 10000;
  localparam int          COARSE_UNIT_US  = 500000;
  localparam int unsigned FINE_TICK_CYC   = FINE_UNIT_US * CLK_MHZ;
  localparam int unsigned COARSE_TICK_CYC = COARSE_UNIT_US * CLK_MHZ;

  // ==========================================================
  // Engine states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_XFER   = 2'b01,
    ST_COMMIT = 2'b10
  } ewd_state_t;

endpackage

/* core/ewd_deadline_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ewd_deadline_timer
  import ewd_pkg::*;
#(
  parameter int unsigned FINE_TICKS   = FINE_TICK_CYC,
  parameter int unsigned COARSE_TICKS = COARSE_TICK_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [7:0] deadline_code,
  // Result
  output logic            expired
);

  logic [31:0] pre_r, pre_nxt;
  logic [7:0]  units_r, units_nxt;
  logic [7:0]  limit_r, limit_nxt;
  logic        coarse_r, coarse_nxt;
  logic        run_r, run_nxt;
  logic        exp_r, exp_nxt;
  logic [31:0] tick_len;

  // ==========================================================
  // Unit counter
  always_comb begin
    pre_nxt    = pre_r;
    units_nxt  = units_r;
    limit_nxt  = limit_r;
    coarse_nxt = coarse_r;
    run_nxt    = run_r;
    exp_nxt    = exp_r;
    tick_len   = coarse_r ? COARSE_TICKS : FINE_TICKS;
    if (start) begin
      // Limit is code low seven bits plus one units
      limit_nxt  = {1'b0, deadline_code[6:0]} + 8'h01;
      coarse_nxt = deadline_code[DL_COARSE];
      pre_nxt    = '0;
      units_nxt  = '0;
      run_nxt    = 1'b1;
      exp_nxt    = 1'b0;
    end else if (stop) begin
      run_nxt = 1'b0;
      exp_nxt = 1'b0;
    end else if (run_r) begin
      if (pre_r == tick_len - 32'h0000_0001) begin
        pre_nxt   = '0;
        units_nxt = units_r + 8'h01;
        if (units_r + 8'h01 == limit_r) begin
          // Expiry only promotes urgency; the command still completes
          exp_nxt = 1'b1;
          run_nxt = 1'b0;
        end
      end else begin
        pre_nxt = pre_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r    <= '0;
      units_r  <= '0;
      limit_r  <= '0;
      coarse_r <= 1'b0;
      run_r    <= 1'b0;
      exp_r    <= 1'b0;
    end else begin
      pre_r    <= pre_nxt;
      units_r  <= units_nxt;
      limit_r  <= limit_nxt;
      coarse_r <= coarse_nxt;
      run_r    <= run_nxt;
      exp_r    <= exp_nxt;
    end
  end

  assign expired = exp_r;

endmodule
`default_nettype wire

/* core/ewd_cmd_decoder.sv */
// Function
// - Command code 35h starts the extended-address DMA write.
// - Sector payload arrives as 16-bit words, one word per transfer.
// - A data word is taken only while the device raises its DMA request.
// - Exactly one interrupt per command, after transfer ends and status is ready.
// - Uncorrectable error stops the extended write at the failing sector.
// - Extended count: low byte current, high byte previous sector-count write.
// - Extended count of zero means 65,536 sectors.
// - 48-bit address from current and previous address register bytes.
// - Media-reported failing address left in address registers, split by high-byte select.
// - Command code 61h starts the queued first-party DMA write.
// - Unrecoverable error ends the queued write at the failing sector.
// - Queued count: low byte current, high byte previous feature write.
// - Urgency class in sector-count previous bits 7-6: normal, isochronous, high.
// - High-urgency queued writes are pushed ahead as best effort.
// - Isochronous queued writes are tried before their deadline.
// - Deadline code counts only when the urgency class is isochronous.
// - Fine deadline: low seven bits plus one, times 10 ms.
// - Coarse deadline: low seven bits plus one, times 0.5 s.
// - Forced-commit flag delays completion of a queued write until data reaches the media; the extended write ignores it.
`timescale 1ns/1ps
`default_nettype none
module ewd_cmd_decoder
  import ewd_pkg::*;
#(
  parameter int          WORDS_PER_SECTOR = 256,
  parameter int          QUEUE_DEPTH      = 32,
  parameter logic [47:0] CAPACITY_SECS    = 48'hFFFF_FFFF_FFFF,
  parameter int unsigned FINE_TICKS       = FINE_TICK_CYC,
  parameter int unsigned COARSE_TICKS     = COARSE_TICK_CYC
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Task-file port
  input  wire logic [TF_AW-1:0] tf_addr,
  input  wire logic [7:0]       tf_wdata,
  input  wire logic             tf_wr,
  input  wire logic             tf_rd,
  output logic      [7:0]       tf_rdata,
  // Host DMA data
  output logic                  dmarq,
  input  wire logic             dma_wr,
  input  wire logic [15:0]      dma_wdata,
  input  wire logic             dma_crc_err,
  output logic                  intrq,
  // Media side
  output logic                  media_wr_valid,
  output logic      [15:0]      media_wr_data,
  output logic      [47:0]      media_lba,
  output logic                  media_urgent,
  output logic                  media_flush_req,
  input  wire logic             media_flush_done,
  input  wire logic             media_fail,
  input  wire logic [47:0]      media_fail_lba
);

  localparam int WCW = $clog2(WORDS_PER_SECTOR);

  ewd_state_t                  state_r, state_nxt;
  logic [7:0]                  cur_r  [NUM_PAIRS];
  logic [7:0]                  cur_nxt [NUM_PAIRS];
  logic [7:0]                  prev_r [NUM_PAIRS];
  logic [7:0]                  prev_nxt [NUM_PAIRS];
  logic [7:0]                  devhead_r, devhead_nxt;
  logic                        hbs_r, hbs_nxt;
  logic [7:0]                  errf_r, errf_nxt;
  logic                        bsy_r, bsy_nxt;
  logic                        errst_r, errst_nxt;
  logic                        intrq_r, intrq_nxt;
  logic [7:0]                  rdata_r, rdata_nxt;
  logic [WCW-1:0]              wcnt_r, wcnt_nxt;
  logic [16:0]                 left_r, left_nxt;
  logic [47:0]                 lba_r, lba_nxt;
  logic                        queued_r, queued_nxt;
  logic                        commit_r, commit_nxt;
  logic [4:0]                  tag_r, tag_nxt;
  logic [1:0]                  urg_r, urg_nxt;
  logic [31:0]                 tag_busy_r, tag_busy_nxt;
  logic                        mwv_r, mwv_nxt;
  logic [15:0]                 mwd_r, mwd_nxt;
  logic                        dl_start, dl_stop, dl_expired;
  logic                        done, done_err;
  logic [47:0]                 fail_addr;
  logic                        fail_load;
  logic [16:0]                 req_count;
  logic [47:0]                 req_lba;
  logic [4:0]                  req_tag;
  logic [48:0]                 req_end;
  logic                        is_ext, is_q;
  logic [7:0]                  status;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] hbs_pick(input logic sel, input logic [7:0] c,
                                          input logic [7:0] p);
    hbs_pick = sel ? p : c;
  endfunction

  function automatic logic [16:0] count_of(input logic [7:0] hi, input logic [7:0] lo);
    count_of = ({hi, lo} == 16'h0000) ? ZERO_COUNT_SECS : {1'b0, hi, lo};
  endfunction

  // ==========================================================
  // Decode of a command write
  always_comb begin
    is_ext    = tf_wr && !bsy_r && tf_addr == TF_CMD_STAT && tf_wdata == OP_WRITE_EXT;
    is_q      = tf_wr && !bsy_r && tf_addr == TF_CMD_STAT
                && tf_wdata == OP_WRITE_QUEUED;
    // Queued count sits in feature, extended in sector count
    req_count = is_q ? count_of(prev_r[PR_FEAT], cur_r[PR_FEAT])
                     : count_of(prev_r[PR_SECCNT], cur_r[PR_SECCNT]);
    req_lba   = {prev_r[PR_CYL_HI], prev_r[PR_CYL_LO], prev_r[PR_SECNUM],
                 cur_r[PR_CYL_HI], cur_r[PR_CYL_LO], cur_r[PR_SECNUM]};
    req_tag   = cur_r[PR_SECCNT][7:TAG_LSB];
    req_end   = {1'b0, req_lba} + {32'h0000_0000, req_count};
  end

  // Status byte; busy, fault and corrected stay clear at completion
  always_comb begin
    status          = 8'h00;
    status[ST_BSY]  = bsy_r;
    status[ST_RDY]  = 1'b1;
    status[ST_FLT]  = 1'b0;
    status[ST_SEEK] = 1'b1;
    status[ST_DRQ]  = state_r == ST_XFER;
    status[ST_CORR] = 1'b0;
    status[ST_ERR]  = errst_r;
  end

  // ==========================================================
  // Engine and task file
  always_comb begin
    state_nxt    = state_r;
    cur_nxt      = cur_r;
    prev_nxt     = prev_r;
    devhead_nxt  = devhead_r;
    hbs_nxt      = hbs_r;
    errf_nxt     = errf_r;
    bsy_nxt      = bsy_r;
    errst_nxt    = errst_r;
    intrq_nxt    = intrq_r;
    rdata_nxt    = 8'h00;
    wcnt_nxt     = wcnt_r;
    left_nxt     = left_r;
    lba_nxt      = lba_r;
    queued_nxt   = queued_r;
    commit_nxt   = commit_r;
    tag_nxt      = tag_r;
    urg_nxt      = urg_r;
    tag_busy_nxt = tag_busy_r;
    mwv_nxt      = 1'b0;
    mwd_nxt      = mwd_r;
    dl_start     = 1'b0;
    dl_stop      = 1'b0;
    done         = 1'b0;
    done_err     = 1'b0;
    fail_load    = 1'b0;
    fail_addr    = media_fail_lba;

    // Register reads; reading status acknowledges the interrupt
    if (tf_rd) begin
      case (tf_addr)
        TF_FEAT_ERR: rdata_nxt = errf_r;
        TF_SECNUM:   rdata_nxt = hbs_pick(hbs_r, cur_r[PR_SECNUM], prev_r[PR_SECNUM]);
        TF_CYL_LO:   rdata_nxt = hbs_pick(hbs_r, cur_r[PR_CYL_LO], prev_r[PR_CYL_LO]);
        TF_CYL_HI:   rdata_nxt = hbs_pick(hbs_r, cur_r[PR_CYL_HI], prev_r[PR_CYL_HI]);
        TF_DEVHEAD:  rdata_nxt = devhead_r;
        TF_CMD_STAT: begin
          rdata_nxt = status;
          intrq_nxt = 1'b0;
        end
        TF_DEVCTL:   rdata_nxt = {hbs_r, 7'h00};
        default:     rdata_nxt = 8'h00;
      endcase
    end

    // Register writes are ignored while busy
    if (tf_wr && !bsy_r) begin
      if (tf_addr >= TF_FEAT_ERR && tf_addr <= TF_CYL_HI) begin
        for (int i = 0; i < NUM_PAIRS; i++) begin
          if (tf_addr == TF_FEAT_ERR + 4'(i)) begin
            prev_nxt[i] = cur_r[i];
            cur_nxt[i]  = tf_wdata;
          end
        end
        hbs_nxt = 1'b0;
      end else if (tf_addr == TF_DEVHEAD) begin
        devhead_nxt = tf_wdata;
        hbs_nxt     = 1'b0;
      end else if (tf_addr == TF_DEVCTL) begin
        hbs_nxt = tf_wdata[DC_HIBYTE];
      end else if (tf_addr == TF_CMD_STAT) begin
        // Host has armed its DMA channel before this write
        bsy_nxt    = 1'b1;
        errst_nxt  = 1'b0;
        errf_nxt   = 8'h00;
        intrq_nxt  = 1'b0;
        wcnt_nxt   = '0;
        left_nxt   = req_count;
        lba_nxt    = req_lba;
        queued_nxt = is_q;
        tag_nxt    = req_tag;
        urg_nxt    = prev_r[PR_SECCNT][7:URG_LSB];
        commit_nxt = is_q && devhead_r[DH_FORCED];
        if (!is_ext && !is_q) begin
          errf_nxt[ER_ABORT] = 1'b1;
          done             = 1'b1;
          done_err         = 1'b1;
        end else if (is_q && ({27'h000_0000, req_tag} >= 32'(QUEUE_DEPTH)
                              || tag_busy_r[req_tag])) begin
          errf_nxt[ER_ABORT] = 1'b1;
          done             = 1'b1;
          done_err         = 1'b1;
        end else if (req_end > {1'b0, CAPACITY_SECS}) begin
          errf_nxt[ER_NOTFND] = 1'b1;
          done             = 1'b1;
          done_err         = 1'b1;
        end else begin
          state_nxt = ST_XFER;
          if (is_q) begin
            tag_busy_nxt[req_tag] = 1'b1;
            // Deadline only runs for the isochronous class
            dl_start = prev_r[PR_SECCNT][7:URG_LSB] == URG_ISOCH;
          end
        end
      end
    end

    case (state_r)
      ST_IDLE: begin
        state_nxt = state_nxt;
      end
      ST_XFER: begin
        if (media_fail || dma_crc_err) begin
          // Stop at the failing sector; no later sector is written
          state_nxt = ST_IDLE;
          fail_load = media_fail;
          errf_nxt[ER_CRC] = dma_crc_err;
          done      = 1'b1;
          done_err  = 1'b1;
        end else if (dma_wr) begin
          // Word counted only under our own request
          mwv_nxt = 1'b1;
          mwd_nxt = dma_wdata;
          if (wcnt_r == WCW'(WORDS_PER_SECTOR - 1)) begin
            wcnt_nxt = '0;
            lba_nxt  = lba_r + 48'h0000_0000_0001;
            left_nxt = left_r - 17'h0_0001;
            if (left_r == 17'h0_0001) begin
              if (commit_r) begin
                state_nxt = ST_COMMIT;
              end else begin
                state_nxt = ST_IDLE;
                done      = 1'b1;
              end
            end
          end else begin
            wcnt_nxt = wcnt_r + WCW'(1);
          end
        end
      end
      ST_COMMIT: begin
        if (media_fail) begin
          state_nxt = ST_IDLE;
          fail_load = 1'b1;
          done      = 1'b1;
          done_err  = 1'b1;
        end else if (media_flush_done) begin
          state_nxt = ST_IDLE;
          done      = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase

    // Single completion point raises the one interrupt
    if (done) begin
      bsy_nxt   = 1'b0;
      errst_nxt = done_err;
      intrq_nxt = 1'b1;
      dl_stop   = 1'b1;
      if (queued_r && state_r != ST_IDLE) begin
        tag_busy_nxt[tag_r] = 1'b0;
      end
    end

    // Failing address replaces the address registers
    if (fail_load) begin
      cur_nxt[PR_SECNUM]  = fail_addr[7:0];
      cur_nxt[PR_CYL_LO]  = fail_addr[15:8];
      cur_nxt[PR_CYL_HI]  = fail_addr[23:16];
      prev_nxt[PR_SECNUM] = fail_addr[31:24];
      prev_nxt[PR_CYL_LO] = fail_addr[39:32];
      prev_nxt[PR_CYL_HI] = fail_addr[47:40];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= ST_IDLE;
      for (int i = 0; i < NUM_PAIRS; i++) begin
        cur_r[i]  <= RST_BYTE;
        prev_r[i] <= RST_BYTE;
      end
      devhead_r  <= RST_BYTE;
      hbs_r      <= 1'b0;
      errf_r     <= RST_BYTE;
      bsy_r      <= 1'b0;
      errst_r    <= 1'b0;
      intrq_r    <= 1'b0;
      rdata_r    <= RST_BYTE;
      wcnt_r     <= '0;
      left_r     <= '0;
      lba_r      <= '0;
      queued_r   <= 1'b0;
      commit_r   <= 1'b0;
      tag_r      <= '0;
      urg_r      <= URG_NORMAL;
      tag_busy_r <= '0;
      mwv_r      <= 1'b0;
      mwd_r      <= '0;
    end else begin
      state_r    <= state_nxt;
      cur_r      <= cur_nxt;
      prev_r     <= prev_nxt;
      devhead_r  <= devhead_nxt;
      hbs_r      <= hbs_nxt;
      errf_r     <= errf_nxt;
      bsy_r      <= bsy_nxt;
      errst_r    <= errst_nxt;
      intrq_r    <= intrq_nxt;
      rdata_r    <= rdata_nxt;
      wcnt_r     <= wcnt_nxt;
      left_r     <= left_nxt;
      lba_r      <= lba_nxt;
      queued_r   <= queued_nxt;
      commit_r   <= commit_nxt;
      tag_r      <= tag_nxt;
      urg_r      <= urg_nxt;
      tag_busy_r <= tag_busy_nxt;
      mwv_r      <= mwv_nxt;
      mwd_r      <= mwd_nxt;
    end
  end

  // ==========================================================
  // Deadline tracking
  ewd_deadline_timer #(
    .FINE_TICKS   (FINE_TICKS),
    .COARSE_TICKS (COARSE_TICKS)
  ) u_deadline (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .start         (dl_start),
    .stop          (dl_stop),
    .deadline_code (prev_r[PR_FEAT]),
    .expired       (dl_expired)
  );

  // ==========================================================
  // Outputs
  assign tf_rdata        = rdata_r;
  assign dmarq           = state_r == ST_XFER;
  assign intrq           = intrq_r;
  assign media_wr_valid  = mwv_r;
  assign media_wr_data   = mwd_r;
  assign media_lba       = lba_r;
  // Media scheduler is told, it cannot be forced; hence best effort only
  assign media_urgent    = queued_r && bsy_r && (urg_r == URG_HIGH
                           || (urg_r == URG_ISOCH && dl_expired));
  assign media_flush_req = state_r == ST_COMMIT;

endmodule
`default_nettype wire

/* verif/ewd_cmd_decoder_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ewd_cmd_decoder_sva
  import ewd_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Task file
  input wire logic [3:0]  tf_addr,
  input wire logic [7:0]  tf_wdata,
  input wire logic        tf_wr,
  input wire logic        tf_rd,
  input wire logic [7:0]  tf_rdata,
  // Host and media
  input wire logic        dmarq,
  input wire logic        dma_wr,
  input wire logic [15:0] dma_wdata,
  input wire logic        dma_crc_err,
  input wire logic        intrq,
  input wire logic        media_wr_valid,
  input wire logic [15:0] media_wr_data,
  input wire logic        media_flush_req,
  input wire logic        media_flush_done,
  input wire logic        media_fail
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ========
  // Checks
  a_cmd_starts_dma: assert property (tf_wr && tf_addr == TF_CMD_STAT
    && tf_wdata == OP_WRITE_EXT && !dmarq && !media_flush_req |=> dmarq)
    else $error("no dma request after command");
  a_word_passes: assert property (dma_wr && dmarq && !media_fail && !dma_crc_err
    |=> media_wr_valid && media_wr_data == $past(dma_wdata)) else $error("word lost");
  a_word_refused: assert property (dma_wr && !dmarq |=> !media_wr_valid)
    else $error("word taken without request");
  a_irq_after_xfer: assert property ($rose(intrq) |-> !dmarq && !media_flush_req)
    else $error("interrupt during transfer");
  a_irq_holds: assert property (intrq && !tf_wr && !tf_rd |=> intrq)
    else $error("interrupt dropped");
  a_rdata_idle: assert property (!tf_rd |=> tf_rdata == 8'h00)
    else $error("read data outside read slot");
  a_commit_holds: assert property (media_flush_req && !media_flush_done && !media_fail
    |=> media_flush_req) else $error("commit wait left early");
  a_fail_stops: assert property (media_fail && dmarq |=> !dmarq)
    else $error("transfer kept going after failure");
  a_fail_no_word: assert property (media_fail |-> ##2 !media_wr_valid)
    else $error("word written after failure");
endmodule
bind ewd_cmd_decoder ewd_cmd_decoder_sva chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .tf_addr(tf_addr), .tf_wdata(tf_wdata), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_rdata(tf_rdata),
  .dmarq(dmarq), .dma_wr(dma_wr), .dma_wdata(dma_wdata), .dma_crc_err(dma_crc_err),
  .intrq(intrq), .media_wr_valid(media_wr_valid), .media_wr_data(media_wr_data),
  .media_flush_req(media_flush_req), .media_flush_done(media_flush_done),
  .media_fail(media_fail));
`default_nettype wire

/* verif/ewd_host_dma.sv */
`timescale 1ns/1ps
`default_nettype none
module ewd_host_dma (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Device side
  input  wire logic        dmarq,
  input  wire logic        slow,
  output logic             dma_wr,
  output logic      [15:0] dma_wdata
);
  logic [1:0] gap_r;
  // ========
  // Word pump; slow mode idles two cycles per word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dma_wr    <= 1'b0;
      dma_wdata <= 16'h0000;
      gap_r     <= 2'h0;
    end else if (dmarq && !dma_wr && gap_r == 2'h0) begin
      dma_wr    <= 1'b1;
      dma_wdata <= dma_wdata + 16'h1357;
      gap_r     <= slow ? 2'h2 : 2'h0;
    end else begin
      dma_wr    <= 1'b0;
      dma_wdata <= ~dma_wdata; // Inverted each idle cycle, so every second idle cycle shows the stale word
      if (gap_r != 2'h0) begin
        gap_r <= gap_r - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/ewd_cmd_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ewd_cmd_decoder_tb;
  import ewd_pkg::*;
  localparam int WPS = 4;
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
  logic        sys_clk, rst_b, tf_wr, tf_rd, dmarq, dma_wr, dma_crc_err, intrq, slow;
  logic        media_wr_valid, media_urgent, media_flush_req, media_flush_done, media_fail;
  logic [3:0]  tf_addr;
  logic [7:0]  tf_wdata, tf_rdata;
  logic [15:0] dma_wdata, media_wr_data;
  logic [47:0] media_lba, media_fail_lba, first_lba;
  logic [7:0]  bad [2];
  int          miscompares, comparisons, nwords;
  ewd_cmd_decoder #(.WORDS_PER_SECTOR(WPS), .QUEUE_DEPTH(8), .FINE_TICKS(4),
    .COARSE_TICKS(8)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .tf_addr(tf_addr),
    .tf_wdata(tf_wdata), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_rdata(tf_rdata), .dmarq(dmarq),
    .dma_wr(dma_wr), .dma_wdata(dma_wdata), .dma_crc_err(dma_crc_err), .intrq(intrq),
    .media_wr_valid(media_wr_valid), .media_wr_data(media_wr_data), .media_lba(media_lba),
    .media_urgent(media_urgent), .media_flush_req(media_flush_req),
    .media_flush_done(media_flush_done), .media_fail(media_fail),
    .media_fail_lba(media_fail_lba));
  ewd_host_dma host (.sys_clk(sys_clk), .rst_b(rst_b), .dmarq(dmarq), .slow(slow),
    .dma_wr(dma_wr), .dma_wdata(dma_wdata));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (media_wr_valid) begin
      if (nwords == 0) first_lba = media_lba;
      nwords++;
    end
  end
  // ========
  // Bus tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    tf_addr  <= a;
    tf_wdata <= d;
    tf_wr    <= 1'b1;
    @(posedge sys_clk);
    tf_wr    <= 1'b0;
  endtask
  task automatic ld(input logic [3:0] a, input logic [7:0] p, input logic [7:0] c);
    wr(a, p);
    wr(a, c);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    tf_addr <= a;
    tf_rd   <= 1'b1;
    @(posedge sys_clk);
    tf_rd   <= 1'b0;
    #1 `CHK(n, e, tf_rdata)
  endtask
  task automatic go(input logic [7:0] c);
    nwords = 0;
    wr(TF_CMD_STAT, c);
  endtask
  task automatic wait_hi(ref logic s, input string n);
    int i;
    i = 0;
    @(posedge sys_clk);
    while (s !== 1'b1 && i < 5000) begin
      @(posedge sys_clk);
      i++;
    end
    #1 `CHK(n, 1'b1, s)
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
  // ========
  // Tests
  initial begin
    {tf_wr, tf_rd, dma_crc_err, media_flush_done, media_fail, slow} = 6'h00;
    {tf_addr, tf_wdata, media_fail_lba} = '0;
    bad = '{OP_WRITE_QUEUED, 8'h20};
    rst_b = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(TF_CMD_STAT, 8'h50, "status");
    rd(4'hF, 8'h00, "unmapped");
    ld(TF_SECCNT, 8'h00, 8'h02);
    for (int k = 0; k < 3; k++) ld(4'(TF_SECNUM + k), 8'hA4 + 8'(k), 8'h01 + 8'(k));
    go(OP_WRITE_EXT);
    wait_hi(intrq, "intrq");
    `CHK("words", 2 * WPS, nwords)
    `CHK("first_lba", 48'hA6A5_A403_0201, first_lba)
    rd(TF_CMD_STAT, 8'h50, "status");
    slow <= 1'b1;
    ld(TF_SECCNT, 8'h00, 8'h01);
    go(OP_WRITE_EXT);
    repeat (3) @(posedge sys_clk);
    dma_crc_err <= 1'b1;
    @(posedge sys_clk);
    dma_crc_err <= 1'b0;
    wait_hi(intrq, "intrq");
    rd(TF_FEAT_ERR, 8'h80, "error");
    rd(TF_CMD_STAT, 8'h51, "status");
    slow <= 1'b0;
    ld(TF_SECCNT, 8'h00, 8'h00);
    go(OP_WRITE_EXT);
    repeat (2200) @(posedge sys_clk);
    #1 `CHK("dmarq", 1'b1, dmarq)
    @(posedge sys_clk);
    media_fail_lba <= 48'h1234_5678_9ABC;
    media_fail     <= 1'b1;
    @(posedge sys_clk);
    media_fail     <= 1'b0;
    wait_hi(intrq, "intrq");
    rd(TF_CMD_STAT, 8'h51, "status");
    for (int k = 0; k < 3; k++) rd(4'(TF_SECNUM + k), 8'hBC - 8'(k * 34), "lba_lo");
    wr(TF_DEVCTL, 8'h80);
    for (int k = 0; k < 3; k++) rd(4'(TF_SECNUM + k), 8'h56 - 8'(k * 34), "lba_hi");
    slow <= 1'b1;
    ld(TF_FEAT_ERR, 8'h00, 8'h01);
    ld(TF_SECCNT, {URG_HIGH, 6'h00}, 8'h28);
    wr(TF_DEVHEAD, 8'h80);
    go(OP_WRITE_QUEUED);
    repeat (2) @(posedge sys_clk);
    #1 `CHK("urgent", 1'b1, media_urgent)
    wait_hi(media_flush_req, "flush_req");
    `CHK("intrq", 1'b0, intrq)
    `CHK("words", WPS, nwords)
    @(posedge sys_clk);
    media_flush_done <= 1'b1;
    @(posedge sys_clk);
    media_flush_done <= 1'b0;
    wait_hi(intrq, "intrq");
    rd(TF_CMD_STAT, 8'h50, "status");
    wr(TF_DEVHEAD, 8'h00);
    ld(TF_FEAT_ERR, 8'h00, 8'h02);
    ld(TF_SECCNT, {URG_ISOCH, 6'h00}, 8'h30);
    go(OP_WRITE_QUEUED);
    repeat (2) @(posedge sys_clk);
    #1 `CHK("urgent", 1'b0, media_urgent)
    repeat (3) @(posedge sys_clk);
    #1 `CHK("urgent", 1'b1, media_urgent)
    wait_hi(intrq, "intrq");
    rd(TF_CMD_STAT, 8'h50, "status");
    ld(TF_FEAT_ERR, 8'h80, 8'h00);
    ld(TF_SECCNT, {URG_ISOCH, 6'h00}, 8'h38);
    go(OP_WRITE_QUEUED);
    repeat (5) @(posedge sys_clk);
    #1 `CHK("urgent", 1'b0, media_urgent)
    repeat (5) @(posedge sys_clk);
    #1 `CHK("urgent", 1'b1, media_urgent)
    @(posedge sys_clk);
    media_fail <= 1'b1;
    @(posedge sys_clk);
    media_fail <= 1'b0;
    wait_hi(intrq, "intrq");
    rd(TF_CMD_STAT, 8'h51, "status");
    ld(TF_SECCNT, 8'h00, 8'hF8);
    foreach (bad[j]) begin
      go(bad[j]);
      wait_hi(intrq, "intrq");
      rd(TF_FEAT_ERR, 8'h04, "error");
      rd(TF_CMD_STAT, 8'h51, "status");
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
